// File: core/ccrs_pkg.sv
// package: constants and types of the core register set and program flow
package ccrs_pkg;
    localparam logic [7:0]  ADDR_POINTER_ONE      = 8'h80;
    localparam logic [7:0]  ADDR_POINTER_SECOND   = 8'h81;
    localparam logic [7:0]  ADDR_BYTE_HOLD_ONE    = 8'h82;
    localparam logic [7:0]  ADDR_BYTE_HOLD_SECOND = 8'h83;
    localparam logic [7:0]  ADDR_ACCUMULATOR      = 8'hff;
    localparam logic [7:0]  RESET_DATA            = 8'h00;
    localparam logic [11:0] RESET_VECTOR          = 12'hffe;
    localparam logic [3:0]  RESET_BANK            = 4'h0;
    localparam int          PC_WIDTH              = 12;
    localparam int          STACK_DEPTH           = 6;
    localparam int          MACHINE_DIV           = 13;
    localparam logic [3:0]  MACHINE_LAST          = 4'(MACHINE_DIV - 1);

    // program counter update source, one per machine cycle
    typedef enum logic [2:0]
    {
        CCRS_PC_NEXT   = 3'h0,
        CCRS_PC_JUMP   = 3'h1,
        CCRS_PC_CALL   = 3'h2,
        CCRS_PC_REL    = 3'h3,
        CCRS_PC_IRQ    = 3'h4,
        CCRS_PC_NMI    = 3'h5,
        CCRS_PC_RET    = 3'h6,
        CCRS_PC_INTERRUPT_EXIT   = 3'h7
    } ccrs_pc_op_e;

    // flag effect of the executing instruction
    typedef enum logic [1:0]
    {
        CCRS_FL_KEEP   = 2'h0,
        CCRS_FL_ARITH  = 2'h1,
        CCRS_FL_LOGIC  = 2'h2,
        CCRS_FL_BTEST  = 2'h3
    } ccrs_flag_op_e;

    // flag contexts, one-hot
    typedef enum logic [2:0]
    {
        CCRS_CTX_NORMAL = 3'b001,
        CCRS_CTX_IRQ    = 3'b010,
        CCRS_CTX_NMI    = 3'b100
    } ccrs_ctx_e;

    typedef struct packed
    {
        logic          valid;
        ccrs_pc_op_e   pc_op;
        logic [11:0]   target;
        logic          rel_sub;
        logic [7:0]    offset;
    } ccrs_flow_s;

    typedef struct packed
    {
        ccrs_flag_op_e op;
        logic [7:0]    result;
        logic          carry;
    } ccrs_flag_s;

    typedef struct packed
    {
        logic          rd;
        logic          wr;
        logic [7:0]    addr;
        logic [7:0]    wdata;
    } ccrs_data_s;

    typedef struct packed
    {
        logic          carry;
        logic          zero;
    } ccrs_pair_s;
endpackage

// File: core/ccrs_return_stack.sv
// six-level shifting return stack without a pointer
module ccrs_return_stack
    import ccrs_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_WIDTH
)
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top,
    output logic                  empty
);
    if (DEPTH < 2 || WIDTH < 1)
    begin
        $error("return stack needs two levels and a nonzero width");
    end

    logic [WIDTH-1:0]         level [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] used;

    assign top   = level[0];
    assign empty = (used == '0);

    // ------------------------------------------------------------
    // level shifting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < DEPTH; i++)
                level[i] <= '0;
        end
        else if (push)
        begin
            // oldest level falls off the bottom
            for (int i = DEPTH - 1; i > 0; i--)
                level[i] <= level[i-1];
            level[0] <= push_data;
        end
        else if (pop && !empty)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                level[i] <= level[i+1];
        end
    end

    // ------------------------------------------------------------
    // fill count, saturating both ways
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            used <= '0;
        else if (push && used != DEPTH[$bits(used)-1:0])
            used <= used + 1'b1;
        else if (!push && pop && !empty)
            used <= used - 1'b1;
    end
endmodule

// File: core/ccrs_core_regs.sv
// core register set: data-space registers, program counter, flags, stack

module ccrs_core_regs
    import ccrs_pkg::*;
#(
    parameter int          BANK_WIDTH = 4,
    parameter logic [11:0] IRQ_VECTOR = 12'hff0,
    parameter logic [11:0] NMI_VECTOR = 12'hffc
)
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire ccrs_flow_s        flow,
    input  wire ccrs_flag_s        flag_upd,
    input  wire ccrs_data_s        data_req,
    input  wire logic [BANK_WIDTH-1:0] bank_in,
    input  wire logic              bank_wr,
    output logic [7:0]             data_rdata,
    output logic                   data_hit,
    output logic [11:0]            fetch_addr,
    output logic [BANK_WIDTH-1:0]  fetch_bank,
    output logic                   machine_tick,
    output ccrs_pair_s             active_flags,
    output ccrs_ctx_e              context_now,
    output logic [7:0]             pointer_one_q,
    output logic [7:0]             pointer_second_q,
    output logic [7:0]             accumulator_q
);
    if (BANK_WIDTH < 1 || BANK_WIDTH > 8)
    begin
        $error("bank width must be 1 to 8");
    end

    function automatic logic hits(input ccrs_data_s r, input logic [7:0] a);
        hits = r.wr && (r.addr == a);
    endfunction

    function automatic logic [11:0] rel_sum(input logic [11:0] pc,
                                            input logic        sub,
                                            input logic [7:0]  off);
        rel_sum = sub ? pc - {4'h0, off} : pc + {4'h0, off};
    endfunction

    logic [7:0]  accumulator;
    logic [7:0]  pointer_one;
    logic [7:0]  pointer_second;
    logic [7:0]  byte_hold_one;
    logic [7:0]  byte_hold_second;
    logic [11:0] pc;
    logic [3:0]  div_count;
    logic        tick;
    ccrs_ctx_e   ctx;
    ccrs_ctx_e   ctx_saved;
    ccrs_pair_s  pair_normal;
    ccrs_pair_s  pair_irq;
    ccrs_pair_s  pair_nmi;
    ccrs_pair_s  next_pair;
    logic        step;
    logic        push;
    logic        pop;
    logic [11:0] stack_top;
    logic        stack_empty;
    logic [7:0]  next_rdata;
    logic        next_hit;

    // ------------------------------------------------------------
    // machine cycle divider
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
            div_count <= 4'h0;
        else if (div_count == MACHINE_LAST)
            div_count <= 4'h0;
        else
            div_count <= div_count + 4'h1;
    end

    assign tick = (div_count == MACHINE_LAST);
    assign step = tick && flow.valid;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            machine_tick <= 1'b0;
        else
            machine_tick <= tick;
    end

    // ------------------------------------------------------------
    // data-space registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            accumulator      <= RESET_DATA;
            pointer_one      <= RESET_DATA;
            pointer_second   <= RESET_DATA;
            byte_hold_one    <= RESET_DATA;
            byte_hold_second <= RESET_DATA;
        end
        else
        begin
            if (hits(data_req, ADDR_ACCUMULATOR))
                accumulator <= data_req.wdata;
            if (hits(data_req, ADDR_POINTER_ONE))
                pointer_one <= data_req.wdata;
            if (hits(data_req, ADDR_POINTER_SECOND))
                pointer_second <= data_req.wdata;
            if (hits(data_req, ADDR_BYTE_HOLD_ONE))
                byte_hold_one <= data_req.wdata;
            if (hits(data_req, ADDR_BYTE_HOLD_SECOND))
                byte_hold_second <= data_req.wdata;
        end
    end

    // read data sees the stored value, not a same-cycle write
    always_comb
    begin
        next_hit   = data_req.rd;
        next_rdata = 8'h00;
        unique case (data_req.addr)
            ADDR_ACCUMULATOR:      next_rdata = accumulator;
            ADDR_POINTER_ONE:      next_rdata = pointer_one;
            ADDR_POINTER_SECOND:   next_rdata = pointer_second;
            ADDR_BYTE_HOLD_ONE:    next_rdata = byte_hold_one;
            ADDR_BYTE_HOLD_SECOND: next_rdata = byte_hold_second;
            default:               next_hit   = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            data_rdata <= 8'h00;
            data_hit   <= 1'b0;
        end
        else
        begin
            data_rdata <= next_hit ? next_rdata : 8'h00;
            data_hit   <= next_hit;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pointer_one_q    <= RESET_DATA;
            pointer_second_q <= RESET_DATA;
            accumulator_q    <= RESET_DATA;
        end
        else
        begin
            pointer_one_q    <= pointer_one;
            pointer_second_q <= pointer_second;
            accumulator_q    <= accumulator;
        end
    end

    // ------------------------------------------------------------
    // program counter and bank
    // ------------------------------------------------------------
    assign push = step && (flow.pc_op == CCRS_PC_CALL
                        || flow.pc_op == CCRS_PC_IRQ
                        || flow.pc_op == CCRS_PC_NMI);
    assign pop  = step && (flow.pc_op == CCRS_PC_RET
                        || flow.pc_op == CCRS_PC_INTERRUPT_EXIT);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            pc <= RESET_VECTOR;
        else if (step)
        begin
            unique case (flow.pc_op)
                CCRS_PC_NEXT: pc <= pc + 12'h001;
                CCRS_PC_JUMP: pc <= flow.target;
                CCRS_PC_CALL: pc <= flow.target;
                CCRS_PC_REL:  pc <= rel_sum(pc, flow.rel_sub,
                                            flow.offset);
                CCRS_PC_IRQ:  pc <= IRQ_VECTOR;
                CCRS_PC_NMI:  pc <= NMI_VECTOR;
                CCRS_PC_RET,
                CCRS_PC_INTERRUPT_EXIT:
                    // empty stack: fall through to next instruction
                    pc <= stack_empty ? pc + 12'h001 : stack_top;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            fetch_addr <= RESET_VECTOR;
        else
            fetch_addr <= pc;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            fetch_bank <= BANK_WIDTH'(RESET_BANK);
        else if (bank_wr)
            fetch_bank <= bank_in;
    end

    // return address: the counter as it stands when the call is taken
    ccrs_return_stack #(
        .DEPTH     (STACK_DEPTH),
        .WIDTH     (PC_WIDTH)
    ) u_stack (
        .core_clk  (core_clk),
        .reset     (reset),
        .push      (push),
        .pop       (pop),
        .push_data (pc),
        .top       (stack_top),
        .empty     (stack_empty)
    );

    // ------------------------------------------------------------
    // flag context
    // ------------------------------------------------------------
    // one saved context only: an exit restores it and leaves the normal context saved
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctx       <= CCRS_CTX_NMI;
            ctx_saved <= CCRS_CTX_NMI;
        end
        else if (step)
        begin
            unique case (flow.pc_op)
                CCRS_PC_IRQ:
                begin
                    ctx_saved <= ctx;
                    ctx       <= CCRS_CTX_IRQ;
                end
                CCRS_PC_NMI:
                begin
                    ctx_saved <= ctx;
                    ctx       <= CCRS_CTX_NMI;
                end
                CCRS_PC_INTERRUPT_EXIT:
                begin
                    ctx       <= ctx_saved;
                    ctx_saved <= CCRS_CTX_NORMAL;
                end
                default:
                    ctx <= ctx;
            endcase
        end
    end

    // ------------------------------------------------------------
    // flag pairs
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (ctx)
            CCRS_CTX_NORMAL: next_pair = pair_normal;
            CCRS_CTX_IRQ:    next_pair = pair_irq;
            CCRS_CTX_NMI:    next_pair = pair_nmi;
            default:         next_pair = pair_nmi;
        endcase
        unique case (flag_upd.op)
            CCRS_FL_KEEP: next_pair = next_pair;
            CCRS_FL_ARITH:
            begin
                next_pair.carry = flag_upd.carry;
                next_pair.zero  = (flag_upd.result == 8'h00);
            end
            CCRS_FL_LOGIC:
                next_pair.zero  = (flag_upd.result == 8'h00);
            CCRS_FL_BTEST:
                next_pair.carry = flag_upd.carry;
        endcase
    end

    // only the active pair is written; on a switch that is the outgoing context's pair
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pair_normal <= '0;
            pair_irq    <= '0;
            pair_nmi    <= '0;
        end
        else if (step)
        begin
            if (ctx == CCRS_CTX_NORMAL)
                pair_normal <= next_pair;
            if (ctx == CCRS_CTX_IRQ)
                pair_irq <= next_pair;
            if (ctx == CCRS_CTX_NMI)
                pair_nmi <= next_pair;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            active_flags <= '0;
            context_now  <= CCRS_CTX_NMI;
        end
        else
        begin
            unique case (ctx)
                CCRS_CTX_NORMAL: active_flags <= pair_normal;
                CCRS_CTX_IRQ:    active_flags <= pair_irq;
                CCRS_CTX_NMI:    active_flags <= pair_nmi;
            endcase
            context_now <= ctx;
        end
    end
endmodule

// File: test/ccrs_checker.sv
// checker: port timing relations of the core register set
module ccrs_checker
    import ccrs_pkg::*;
#(
    parameter logic [11:0] IRQ_VECTOR = 12'hff0,
    parameter logic [11:0] NMI_VECTOR = 12'hffc
)
(
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire ccrs_flow_s  flow,
    input  wire ccrs_flag_s  flag_upd,
    input  wire ccrs_data_s  data_req,
    input  wire logic [7:0]  data_rdata,
    input  wire logic        data_hit,
    input  wire logic [11:0] fetch_addr,
    input  wire logic        machine_tick,
    input  wire ccrs_pair_s  active_flags,
    input  wire ccrs_ctx_e   context_now,
    input  wire logic [7:0]  accumulator_q
);
    timeunit 1ns;
    timeprecision 1ps;
    ccrs_flow_s fl_q;
    ccrs_flag_s fg_q;
    logic       mapped;
    // the tick pulse trails the taking edge, so keep what that edge saw
    always_ff @(posedge core_clk) fl_q <= flow;
    always_ff @(posedge core_clk) fg_q <= flag_upd;
    assign mapped = data_req.addr inside
        {[ADDR_POINTER_ONE:ADDR_BYTE_HOLD_SECOND], ADDR_ACCUMULATOR};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_took(ccrs_pc_op_e o);
        machine_tick && fl_q.valid && fl_q.pc_op == o;
    endsequence
    // flag checks only where no context switch interferes
    sequence s_flags(ccrs_flag_op_e f);
        machine_tick && fl_q.valid && fg_q.op == f && fl_q.pc_op inside
            {CCRS_PC_NEXT, CCRS_PC_JUMP, CCRS_PC_CALL, CCRS_PC_REL};
    endsequence

    a_tick_period: assert property (machine_tick |=>
        (!machine_tick)[*8] ##1 (!machine_tick)[*4] ##1 machine_tick)
        else $error("tick");
    a_map_hit: assert property (
        data_req.rd && mapped |=> data_hit) else $error("hit");
    a_unmapped_zero: assert property (data_req.rd && !mapped
        |=> !data_hit && data_rdata == 8'h00) else $error("unmapped");
    a_acc_write: assert property (data_req.wr
        && data_req.addr == ADDR_ACCUMULATOR ##1 !data_req.wr
        |=> accumulator_q == $past(data_req.wdata, 2)) else $error("acc");
    a_jump_load: assert property (s_took(CCRS_PC_JUMP)
        |=> fetch_addr == $past(fl_q.target)) else $error("jump");
    a_next_step: assert property (s_took(CCRS_PC_NEXT)
        |=> fetch_addr == 12'($past(fetch_addr) + 12'h001))
        else $error("next");
    a_rel_sum: assert property (s_took(CCRS_PC_REL) |=> fetch_addr ==
        ($past(fl_q.rel_sub) ? $past(fetch_addr) - {4'h0, $past(fl_q.offset)}
        : $past(fetch_addr) + {4'h0, $past(fl_q.offset)}))
        else $error("rel");
    a_irq_entry: assert property (s_took(CCRS_PC_IRQ) |=> fetch_addr ==
        IRQ_VECTOR && context_now == CCRS_CTX_IRQ) else $error("irq");
    a_nmi_entry: assert property (s_took(CCRS_PC_NMI) |=> fetch_addr ==
        NMI_VECTOR && context_now == CCRS_CTX_NMI) else $error("nmi");
    a_flags_keep: assert property (s_flags(CCRS_FL_KEEP)
        |=> $stable(active_flags)) else $error("keep");
    a_arith_flags: assert property (s_flags(CCRS_FL_ARITH)
        |=> active_flags == {$past(fg_q.carry), $past(fg_q.result) == 8'h00})
        else $error("arith");
    a_btest_carry: assert property (s_flags(CCRS_FL_BTEST)
        |=> active_flags.carry == $past(fg_q.carry)) else $error("btest");
    a_reset_state: assert property (@(posedge core_clk)
        disable iff (1'b0)
        reset |=> fetch_addr == RESET_VECTOR && context_now == CCRS_CTX_NMI)
        else $error("reset");
endmodule

bind ccrs_core_regs ccrs_checker #(
    .IRQ_VECTOR(IRQ_VECTOR),
    .NMI_VECTOR(NMI_VECTOR)
) chk (
    .core_clk(core_clk),
    .reset(reset),
    .flow(flow),
    .flag_upd(flag_upd),
    .data_req(data_req),
    .data_rdata(data_rdata),
    .data_hit(data_hit),
    .fetch_addr(fetch_addr),
    .machine_tick(machine_tick),
    .active_flags(active_flags),
    .context_now(context_now),
    .accumulator_q(accumulator_q)
);

// File: test/ccrs_prog_mem.sv
// program memory model answering the fetch stream
module ccrs_prog_mem
(
    input  wire logic        core_clk,
    input  wire logic [11:0] fetch_addr,
    input  wire logic [3:0]  fetch_bank,
    output logic [7:0]       code
);
    timeunit 1ns;
    timeprecision 1ps;
    // full 12-bit reach per bank; contents are an address-made pattern
    always_ff @(posedge core_clk)
    begin
        code <= fetch_addr[7:0] ^ {fetch_addr[11:8], fetch_bank};
    end
endmodule

// File: test/ccrs_core_regs_test.sv
// testbench: register access, program flow, flags and return stack
module ccrs_core_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ccrs_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    ccrs_flow_s  flow = '0;
    ccrs_flag_s  flag_upd = '0;
    ccrs_data_s  data_req = '0;
    logic [3:0]  bank_in = 4'h0;
    logic        bank_wr = 1'b0;
    logic [7:0]  data_rdata, p1, p2, acc, code, d;
    logic        data_hit, machine_tick, h;
    logic [11:0] fetch_addr, exp_pc;
    logic [3:0]  fetch_bank;
    ccrs_pair_s  active_flags;
    ccrs_ctx_e   context_now;
    logic [11:0] stk[$];
    logic [7:0]  amap[6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
    int          fail_count = 0;
    int          checks_done = 0;

    always #4 core_clk = ~core_clk;

    ccrs_core_regs dut (
        .core_clk(core_clk), .reset(reset), .flow(flow),
        .flag_upd(flag_upd), .data_req(data_req), .bank_in(bank_in),
        .bank_wr(bank_wr), .data_rdata(data_rdata), .data_hit(data_hit),
        .fetch_addr(fetch_addr), .fetch_bank(fetch_bank),
        .machine_tick(machine_tick), .active_flags(active_flags),
        .context_now(context_now), .pointer_one_q(p1),
        .pointer_second_q(p2), .accumulator_q(acc)
    );
    ccrs_prog_mem mem (
        .core_clk(core_clk), .fetch_addr(fetch_addr),
        .fetch_bank(fetch_bank), .code(code)
    );

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk) data_req = '{1'b0, 1'b1, a, v};
        @(negedge core_clk) data_req = '0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] v, output logic hit);
        @(negedge core_clk) data_req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge core_clk) v = data_rdata;
        hit = data_hit;
        data_req = '0;
    endtask

    // ----------------------------------------
    // one machine-cycle operation, checked against a shifting stack model
    // ----------------------------------------
    task op(input ccrs_pc_op_e o, input logic [11:0] t = 12'h000,
            input logic s = 1'b0, input logic [7:0] off = 8'h00,
            input ccrs_flag_op_e f = CCRS_FL_KEEP,
            input logic [7:0] r = 8'h01, input logic c = 1'b0);
        int n;
        @(negedge core_clk) flow = '{1'b1, o, t, s, off};
        flag_upd = '{f, r, c};
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (machine_tick !== 1'b1 && n < 30);
        if (n >= 30)
            fail_count++;
        flow.valid = 1'b0;
        if (o inside {CCRS_PC_CALL, CCRS_PC_IRQ, CCRS_PC_NMI})
        begin
            stk.push_front(exp_pc);
            if (stk.size() > 6)
                void'(stk.pop_back());
        end
        case (o)
            CCRS_PC_NEXT: exp_pc = exp_pc + 12'h001;
            CCRS_PC_REL:  exp_pc = s ? exp_pc - off : exp_pc + off;
            CCRS_PC_IRQ:  exp_pc = 12'hff0;
            CCRS_PC_NMI:  exp_pc = 12'hffc;
            CCRS_PC_RET, CCRS_PC_INTERRUPT_EXIT:
                exp_pc = stk.size() > 0 ? stk.pop_front() : exp_pc + 12'h001;
            default:      exp_pc = t;
        endcase
        @(negedge core_clk) cmp(fetch_addr, exp_pc);
    endtask

    task chk_fc(input ccrs_ctx_e cx, input logic c, input logic z);
        cmp(context_now, cx);
        cmp(active_flags, {c, z});
    endtask

    initial
    begin
        #50000;
        fail_count++;
        close_out();
    end

    initial
    begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        cmp(fetch_addr, RESET_VECTOR);
        chk_fc(CCRS_CTX_NMI, 1'b0, 1'b0);
        exp_pc = RESET_VECTOR;
        $display("test reset done");
        for (int i = 0; i < 6; i++)
            wr(amap[i], 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 6; i++)
        begin
            rd(amap[i], d, h);
            cmp(d, i < 5 ? 8'(8'h11 * (i + 1)) : 8'h00);
            cmp(h, i < 5);
        end
        cmp({p1, p2}, 16'h1122);
        cmp(acc, 8'h55);
        @(negedge core_clk) bank_in = 4'ha;
        bank_wr = 1'b1;
        @(negedge core_clk) bank_wr = 1'b0;
        cmp(fetch_bank, 4'ha);
        $display("test data space done");
        op(CCRS_PC_NEXT);
        op(CCRS_PC_NEXT);
        op(CCRS_PC_JUMP, 12'h100);
        @(negedge core_clk) cmp(code, 8'h1a);
        op(CCRS_PC_REL, 12'h000, 1'b0, 8'h10);
        op(CCRS_PC_REL, 12'h000, 1'b1, 8'h20);
        op(.o(CCRS_PC_NEXT), .f(CCRS_FL_LOGIC), .r(8'h05));
        cmp(active_flags.zero, 1'b0);
        op(.o(CCRS_PC_NEXT), .f(CCRS_FL_BTEST), .c(1'b1));
        cmp(active_flags.carry, 1'b1);
        op(.o(CCRS_PC_NEXT), .f(CCRS_FL_ARITH), .r(8'h00), .c(1'b1));
        chk_fc(CCRS_CTX_NMI, 1'b1, 1'b1);
        op(.o(CCRS_PC_NEXT), .r(8'h07));
        chk_fc(CCRS_CTX_NMI, 1'b1, 1'b1);
        $display("test flow and flags done");
        for (int i = 1; i < 8; i++)
            op(CCRS_PC_CALL, 12'(i * 16'h0101));
        op(CCRS_PC_IRQ);
        chk_fc(CCRS_CTX_IRQ, 1'b0, 1'b0);
        op(.o(CCRS_PC_NEXT), .f(CCRS_FL_ARITH), .r(8'h00));
        chk_fc(CCRS_CTX_IRQ, 1'b0, 1'b1);
        op(CCRS_PC_INTERRUPT_EXIT);
        chk_fc(CCRS_CTX_NMI, 1'b1, 1'b1);
        for (int i = 0; i < 6; i++)
            op(CCRS_PC_RET);
        op(CCRS_PC_INTERRUPT_EXIT);
        chk_fc(CCRS_CTX_NORMAL, 1'b0, 1'b0);
        op(CCRS_PC_NMI);
        chk_fc(CCRS_CTX_NMI, 1'b1, 1'b1);
        $display("test stack and contexts done");
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        cmp(fetch_addr, RESET_VECTOR);
        chk_fc(CCRS_CTX_NMI, 1'b0, 1'b0);
        $display("test second reset done");
        close_out();
    end
endmodule
